// ### rtl/tcaf_port.sv
// The AXI4-Lite slave port and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "tcaf_map.svh"

module tcaf_port (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bit_clock,
  input wire logic frame_start,
  input wire logic serial_frame_in,
  input wire logic chain_token_in,
  output logic serial_data_out,
  output logic serial_data_out_en,
  output logic chain_token_out,
  output logic [23:0] audio_left,
  output logic [23:0] audio_right,
  output logic audio_strobe,
  output logic mode_active,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  tcaf_pkg::tcaf_state_t s;
  tcaf_pkg::tcaf_state_t next_s;
  tcaf_pkg::tcaf_cmd_t cmd;
  tcaf_pkg::tcaf_cmd_t hdr;
  logic rise;
  logic fall;
  logic fs;
  logic din;
  logic tok;
  logic start;
  logic [4:0] idx;
  logic [5:0] slot;
  logic [31:0] field;
  logic out_disabled;
  logic cmd_slot;
  logic hdr_slot;
  logic normal;
  logic [4:0] new_id;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    cmd = tcaf_pkg::tcaf_cmd_t'(32'h0000_0000);
    hdr = tcaf_pkg::tcaf_cmd_t'(32'h0000_0000);
    start = 1'b0;
    idx = 5'h00;
    slot = 6'h00;
    field = 32'h0000_0000;
    cmd_slot = 1'b0;
    hdr_slot = 1'b0;
    new_id = `TCAF_ID_HEAD;
    // Pin synchronisers
    next_s.bit_clk_sync = {s.bit_clk_sync[1:0], bit_clock};
    next_s.fs_sync = {s.fs_sync[0], frame_start};
    next_s.din_sync = {s.din_sync[0], serial_frame_in};
    next_s.tok_sync = {s.tok_sync[0], chain_token_in};
    rise = s.bit_clk_sync[1] & ~s.bit_clk_sync[2];
    fall = ~s.bit_clk_sync[1] & s.bit_clk_sync[2];
    fs = s.fs_sync[1];
    din = s.din_sync[1];
    tok = s.tok_sync[1];
    out_disabled = s.regs[`TCAF_REG_OUT_CFG][`TCAF_OUT_DIS_BIT];
    normal = s.frame_ok && !s.id_frame && !s.ext_frame;
    next_s.audio_strobe = 1'b0;

    // --------------------------------------------------------------
    // Bus slave
    // --------------------------------------------------------------
    if (s_axi_awvalid && s.awready) begin
      next_s.aw_got = 1'b1;
      next_s.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s.wready) begin
      next_s.w_got = 1'b1;
      next_s.w_data = s_axi_wdata;
      next_s.w_strb = s_axi_wstrb;
    end
    if (s.aw_got && s.w_got && !s.bvalid) begin
      next_s.aw_got = 1'b0;
      next_s.w_got = 1'b0;
      next_s.bvalid = 1'b1;
      next_s.bresp = `TCAF_RESP_OKAY;
      case (s.aw_addr)
        `TCAF_AXI_STATUS, `TCAF_AXI_LEFT, `TCAF_AXI_RIGHT: begin
          next_s.bresp = `TCAF_RESP_OKAY;
        end
        `TCAF_AXI_REG_SEL: begin
          if (s.w_strb[0]) begin
            next_s.reg_sel = s.w_data[6:0];
          end
        end
        `TCAF_AXI_REG_DATA: begin
          if (s.w_strb[0]) begin
            next_s.regs[s.reg_sel] = s.w_data[7:0];
          end
        end
        default: begin
          next_s.bresp = `TCAF_RESP_SLVERR;
        end
      endcase
    end
    if (s.bvalid && s_axi_bready) begin
      next_s.bvalid = 1'b0;
    end
    if (s_axi_arvalid && s.arready) begin
      next_s.rvalid = 1'b1;
      next_s.rresp = `TCAF_RESP_OKAY;
      next_s.rdata = 32'h0000_0000;
      case (s_axi_araddr)
        `TCAF_AXI_STATUS: begin
          next_s.rdata[0] = s.mode_active;
          next_s.rdata[1] = s.id_valid;
          next_s.rdata[12:8] = s.dev_id;
        end
        `TCAF_AXI_LEFT: begin
          next_s.rdata[23:0] = s.left;
        end
        `TCAF_AXI_RIGHT: begin
          next_s.rdata[23:0] = s.right;
        end
        `TCAF_AXI_REG_SEL: begin
          next_s.rdata[6:0] = s.reg_sel;
        end
        `TCAF_AXI_REG_DATA: begin
          next_s.rdata[7:0] = s.regs[s.reg_sel];
        end
        default: begin
          next_s.rresp = `TCAF_RESP_SLVERR;
        end
      endcase
    end
    if (s.rvalid && s_axi_rready) begin
      next_s.rvalid = 1'b0;
    end
    next_s.awready = !next_s.aw_got && !next_s.bvalid;
    next_s.wready = !next_s.w_got && !next_s.bvalid;
    next_s.arready = !next_s.rvalid;

    // --------------------------------------------------------------
    // Rising bit clock: sample and decode
    // --------------------------------------------------------------
    if (rise) begin
      next_s.fs_prev = fs;
      start = fs && !s.fs_prev;
      idx = start ? 5'h00 : s.bit_cnt;
      slot = start ? 6'h00 : s.slot;
      field = {s.shreg[30:0], din};
      next_s.shreg = field;
      next_s.bit_cnt = idx + 5'h01;
      next_s.slot = slot;
      if (idx == `TCAF_LAST_BIT && slot != `TCAF_SLOT_MAX) begin
        next_s.slot = slot + 6'h01;
      end
      // Frame pulse width and mode entry
      if (start) begin
        next_s.fs_len = 3'h1;
        next_s.frame_ok = s.mode_active;
        next_s.id_frame = 1'b0;
        next_s.ext_frame = 1'b0;
        next_s.id_got = 1'b0;
        next_s.id_cnt = 6'h00;
        next_s.own_start = 6'h01;
        next_s.own_known = s.id_valid && s.dev_id == `TCAF_ID_HEAD;
        next_s.tok_level = 1'b0;
      end else if (fs && s.fs_len != `TCAF_FS_LEN_MAX) begin
        next_s.fs_len = s.fs_len + 3'h1;
      end else if (!fs && s.fs_prev) begin
        if (s.fs_len == `TCAF_FS_PULSE_LEN) begin
          if (s.valid_cnt != `TCAF_MODE_FRAMES) begin
            next_s.valid_cnt = s.valid_cnt + 2'h1;
          end
          if (s.valid_cnt + 2'h1 >= `TCAF_MODE_FRAMES) begin
            next_s.mode_active = 1'b1;
          end
        end else begin
          next_s.valid_cnt = 2'h0;
          next_s.mode_active = 1'b0;
          next_s.frame_ok = 1'b0;
        end
      end
      // Early read decision from the header bits
      hdr = tcaf_pkg::tcaf_cmd_t'({field[14:0], 17'h0_0000});
      hdr_slot = s.frame_ok && !start
        && ((slot == 6'h00 && !hdr.id_assign_enable_flag)
        || (slot == 6'h01 && s.ext_frame));
      if (hdr_slot && idx == `TCAF_RD_EARLY_BIT && hdr.rd
          && !hdr.chain_select_flag && s.id_valid
          && hdr.dev_id == s.dev_id) begin
        next_s.tx_cnt = `TCAF_TX_ENABLE;
      end
      if (idx == `TCAF_RD_ADDR_BIT) begin
        next_s.rd_data = s.regs[field[6:0]];
      end
      // Full field decode
      if (idx == `TCAF_LAST_BIT) begin
        cmd = tcaf_pkg::tcaf_cmd_t'(field);
        if (slot == 6'h00 && s.frame_ok) begin
          next_s.id_frame = cmd.id_assign_enable_flag;
          next_s.ext_frame = !cmd.id_assign_enable_flag
            && cmd.extended_command_flag;
        end
        cmd_slot = s.frame_ok
          && ((slot == 6'h00 && !cmd.id_assign_enable_flag)
          || (slot == 6'h01 && s.ext_frame));
        if (cmd_slot && !cmd.rd && !cmd.chain_select_flag
            && cmd.dev_id != `TCAF_ID_NONE
            && ((s.id_valid && cmd.dev_id == s.dev_id)
            || cmd.dev_id == `TCAF_ID_BCAST)) begin
          next_s.regs[cmd.reg_id] = cmd.data;
        end
        // Own audio slots
        if (normal && s.own_known && !out_disabled && s.id_valid
            && slot != 6'h00) begin
          if (slot == s.own_start) begin
            next_s.left = field[31:8];
          end
          if (slot == s.own_start + 6'h01) begin
            next_s.right = field[31:8];
            next_s.audio_strobe = 1'b1;
          end
        end
      end
      // Device ID determination
      if (s.id_frame && slot != 6'h00) begin
        if (s.id_cnt != `TCAF_SLOT_MAX) begin
          next_s.id_cnt = s.id_cnt + 6'h01;
        end
        if (!s.id_got && tok) begin
          if (s.id_cnt >= {1'b0, `TCAF_ID_MAX}) begin
            new_id = `TCAF_ID_MAX;
          end else begin
            new_id = s.id_cnt[4:0] + 5'h01;
          end
          next_s.dev_id = new_id;
          next_s.id_valid = 1'b1;
          next_s.id_got = 1'b1;
          next_s.regs[`TCAF_REG_DEV_ID] = {3'h0, new_id};
          next_s.tok_level = 1'b1;
        end
      end else if (!start) begin
        // Token handling in command and audio frames
        if (normal && !s.own_known && s.id_valid && slot != 6'h00
            && tok) begin
          next_s.own_known = 1'b1;
          next_s.own_start = slot + 6'h01;
        end
        if (out_disabled || !s.id_valid || !normal) begin
          next_s.tok_level = tok;
        end else begin
          next_s.tok_level = s.own_known
            && slot == s.own_start + 6'h01;
        end
      end
    end

    // --------------------------------------------------------------
    // Falling bit clock: drive outputs
    // --------------------------------------------------------------
    if (fall) begin
      next_s.tok_out = s.tok_level;
      if (s.tx_cnt == `TCAF_TX_ENABLE) begin
        next_s.sdo_en = 1'b1;
        next_s.sdo = 1'b0;
        next_s.tx_cnt = s.tx_cnt + 4'h1;
      end else if (s.tx_cnt == `TCAF_TX_END) begin
        next_s.sdo_en = 1'b0;
        next_s.sdo = 1'b0;
        next_s.tx_cnt = 4'h0;
      end else if (s.tx_cnt != 4'h0) begin
        next_s.sdo = s.rd_data[3'(`TCAF_TX_BIAS - s.tx_cnt)];
        next_s.tx_cnt = s.tx_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign serial_data_out = s.sdo;
  assign serial_data_out_en = s.sdo_en;
  assign chain_token_out = s.tok_out;
  assign audio_left = s.left;
  assign audio_right = s.right;
  assign audio_strobe = s.audio_strobe;
  assign mode_active = s.mode_active;
  assign s_axi_awready = s.awready;
  assign s_axi_wready = s.wready;
  assign s_axi_bresp = s.bresp;
  assign s_axi_bvalid = s.bvalid;
  assign s_axi_arready = s.arready;
  assign s_axi_rdata = s.rdata;
  assign s_axi_rresp = s.rresp;
  assign s_axi_rvalid = s.rvalid;

endmodule : tcaf_port

// ### rtl/tcaf_map.svh
`ifndef TCAF_MAP_SVH
`define TCAF_MAP_SVH
// Summary of operation
// - Every field is 32 bits, low byte ignored
// - Fields shift most significant bit first
// - Bit 30 set: extended command field follows
// - Extended command frames carry no audio
// - Bit 31 set: frame only assigns IDs
// - Bit 29 low addresses this input chain
// - Bits 28:24 hold device ID, head is 1
// - ID 0x1F broadcasts writes, 0x00 selects none
// - Bit 23 high reads, low writes
// - Bits 22:16 register, bits 15:8 data
// - Bits 7:0 never sent on readback
// - Extended field decodes like command, no ID flag
// - Two audio slots unless output disable set
// - Assigned device ID readable in register 23
// - Read data returned on three-state output
// - Sample input on rise, drive on fall
// - Output driver enabled one bit early
// - Token out high during last own slot
// - Inactive device passes token straight through
// - Two-bit-clock frame pulse marks this mode
// - Mode after two frames, commands next frame
// - ID found by counting bits, watching token

// ----------------------------------------------------------------
// Frame timing
// ----------------------------------------------------------------
`define TCAF_LAST_BIT 5'h1f
`define TCAF_RD_EARLY_BIT 5'h0e
`define TCAF_RD_ADDR_BIT 5'h0f
`define TCAF_SLOT_MAX 6'h3f
`define TCAF_FS_PULSE_LEN 3'h2
`define TCAF_FS_LEN_MAX 3'h7
`define TCAF_MODE_FRAMES 2'h2
`define TCAF_TX_ENABLE 4'h1
`define TCAF_TX_LAST 4'h9
`define TCAF_TX_END 4'ha
`define TCAF_TX_BIAS 4'h9

// ----------------------------------------------------------------
// Device IDs and device registers
// ----------------------------------------------------------------
`define TCAF_ID_NONE 5'h00
`define TCAF_ID_HEAD 5'h01
`define TCAF_ID_MAX 5'h1e
`define TCAF_ID_BCAST 5'h1f
`define TCAF_REG_OUT_CFG 7'h13
`define TCAF_REG_DEV_ID 7'h17
`define TCAF_OUT_DIS_BIT 4

// ----------------------------------------------------------------
// Bus map
// ----------------------------------------------------------------
`define TCAF_AXI_STATUS 8'h00
`define TCAF_AXI_LEFT 8'h04
`define TCAF_AXI_RIGHT 8'h08
`define TCAF_AXI_REG_SEL 8'h0c
`define TCAF_AXI_REG_DATA 8'h10
`define TCAF_RESP_OKAY 2'h0
`define TCAF_RESP_SLVERR 2'h2
`endif

// ### rtl/tcaf_pkg.sv
package tcaf_pkg;
  typedef struct packed {
    logic id_assign_enable_flag;
    logic extended_command_flag;
    logic chain_select_flag;
    logic [4:0] dev_id;
    logic rd;
    logic [6:0] reg_id;
    logic [7:0] data;
    logic [7:0] unused;
  } tcaf_cmd_t;

  typedef struct packed {
    logic [2:0] bit_clk_sync;
    logic [1:0] fs_sync;
    logic [1:0] din_sync;
    logic [1:0] tok_sync;
    logic fs_prev;
    logic [2:0] fs_len;
    logic [1:0] valid_cnt;
    logic mode_active;
    logic frame_ok;
    logic [4:0] bit_cnt;
    logic [5:0] slot;
    logic [31:0] shreg;
    logic id_frame;
    logic ext_frame;
    logic [4:0] dev_id;
    logic id_valid;
    logic id_got;
    logic [5:0] id_cnt;
    logic [5:0] own_start;
    logic own_known;
    logic tok_level;
    logic [3:0] tx_cnt;
    logic [7:0] rd_data;
    logic [23:0] left;
    logic [23:0] right;
    logic audio_strobe;
    logic sdo;
    logic sdo_en;
    logic tok_out;
    logic [127:0][7:0] regs;
    logic [6:0] reg_sel;
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tcaf_state_t;
endpackage : tcaf_pkg

// ### verification/tcaf_host.sv
`timescale 1ns/1ps
module tcaf_host (
  output logic bit_clock,
  output logic frame_start,
  output logic serial_frame_in,
  output logic chain_token_in,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  input wire logic chain_token_out
);
  logic [127:0] tok_seen;
  logic [7:0] rd_byte;
  int en_hits;
  initial begin
    bit_clock = 1'b0;
    frame_start = 1'b0;
    serial_frame_in = 1'b0;
    chain_token_in = 1'b0;
  end
  task automatic frame(input logic [3:0][31:0] w, input int fs_len,
    input int tok_rise, input int rd_slot);
    int i;
    en_hits = 0;
    for (i = 0; i < 128; i++) begin
      serial_frame_in = w[i / 32][31 - i % 32];
      frame_start = (i < fs_len);
      chain_token_in = (i >= tok_rise);
      #62.5 bit_clock = 1'b1;
      tok_seen[i] = chain_token_out;
      en_hits += int'(serial_data_out_en);
      if (i / 32 == rd_slot && i % 32 > 15 && i % 32 < 24) begin
        rd_byte[23 - i % 32] = serial_data_out;
      end
      #62.5 bit_clock = 1'b0;
    end
    serial_frame_in = ~serial_frame_in;
    #250;
  endtask : frame
endmodule : tcaf_host

// ### verification/tcaf_port_chk.sv
`timescale 1ns/1ps
module tcaf_port_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bit_clock,
  input wire logic serial_data_out,
  input wire logic serial_data_out_en,
  input wire logic chain_token_out,
  input wire logic [23:0] audio_right,
  input wire logic audio_strobe,
  input wire logic mode_active,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid
);
  logic [7:0] en_cnt;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      en_cnt <= 8'h00;
    end else begin
      en_cnt <= serial_data_out_en ? en_cnt + 8'h01 : 8'h00;
    end
  end
  sequence s_ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence s_en_end;
    $fell(serial_data_out_en);
  endsequence
  a_rd_answer: assert property (s_ar_take |=> s_axi_rvalid)
    else $error("read answer late");
  a_sdo_fall: assert property
    ($changed(serial_data_out) |-> !bit_clock) else $error("data moved");
  a_en_fall: assert property
    ($changed(serial_data_out_en) |-> !bit_clock) else $error("enable moved");
  a_tok_fall: assert property
    ($rose(chain_token_out) |-> !bit_clock) else $error("token moved");
  a_en_early: assert property
    ($rose(serial_data_out_en) |-> !serial_data_out) else $error("early bit");
  a_rd_window: assert property
    (s_en_end |-> en_cnt > 8'h6d && en_cnt < 8'h74) else $error("read span");
  a_rd_bound: assert property
    (en_cnt < 8'h75) else $error("driver stuck on");
  a_act_mode: assert property
    (serial_data_out_en || audio_strobe |-> mode_active) else $error("no mode");
  a_strobe_one: assert property
    (audio_strobe |=> !audio_strobe) else $error("strobe too long");
  a_right_strobe: assert property
    ($changed(audio_right) |-> audio_strobe || $past(audio_strobe))
    else $error("sample without strobe");
endmodule : tcaf_port_chk

bind tcaf_port tcaf_port_chk tcaf_port_chk_inst (.aclk, .aresetn,
  .bit_clock, .serial_data_out, .serial_data_out_en, .chain_token_out,
  .audio_right, .audio_strobe, .mode_active, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid);

// ### verification/tcaf_port_bench.sv
`timescale 1ns/1ps
`include "tcaf_map.svh"
module tcaf_port_bench;
  logic aclk, aresetn, bit_clock, frame_start, serial_frame_in;
  logic chain_token_in, serial_data_out, serial_data_out_en;
  logic chain_token_out, audio_strobe, mode_active;
  logic [23:0] audio_left, audio_right;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, r;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  int err_total, total_checks;
  tcaf_host tcaf_host_inst (.bit_clock, .frame_start, .serial_frame_in,
    .chain_token_in, .serial_data_out, .serial_data_out_en,
    .chain_token_out);
  tcaf_port tcaf_port_inst (.aclk, .aresetn, .bit_clock, .frame_start,
    .serial_frame_in, .chain_token_in, .serial_data_out,
    .serial_data_out_en, .chain_token_out, .audio_left, .audio_right,
    .audio_strobe, .mode_active, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    total_checks++;
    if (s !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= v;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        break;
      end
    end
  endtask : axi_wr
  task automatic axi_rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        break;
      end
    end
  endtask : axi_rd
  task automatic wreg(input logic [6:0] n, input logic [7:0] v);
    axi_wr(`TCAF_AXI_REG_SEL, 32'(n));
    axi_wr(`TCAF_AXI_REG_DATA, 32'(v));
  endtask : wreg
  task automatic dreg(input logic [6:0] n, input logic [7:0] v);
    axi_wr(`TCAF_AXI_REG_SEL, 32'(n));
    axi_rd(`TCAF_AXI_REG_DATA);
    chk("dev_reg", d, 32'(v));
  endtask : dreg
  function automatic logic [31:0] cmd(input logic [2:0] f,
    input logic [4:0] id, input logic rd, input logic [6:0] n,
    input logic [7:0] v);
    return {f, id, rd, n, v, 8'h00};
  endfunction : cmd
  task automatic fr(input logic [3:0][31:0] w, input int t, input int s);
    tcaf_host_inst.frame(w, 2, t, s);
  endtask : fr
  task automatic t_axi;
    axi_rd(`TCAF_AXI_STATUS);
    chk("status_rst", d, 32'h0);
    axi_rd(8'h40);
    chk("rresp_bad", 32'(r), 32'h2);
    axi_wr(8'h40, 32'h0);
    chk("bresp_bad", 32'(r), 32'h2);
    axi_wr(`TCAF_AXI_REG_SEL, 32'hffff_ffff);
    axi_rd(`TCAF_AXI_REG_SEL);
    chk("reg_sel", d, 32'h7f);
  endtask : t_axi
  task automatic t_mode;
    fr('0, 0, 9);
    fr('0, 0, 9);
    chk("mode_on", 32'(mode_active), 32'h1);
    tcaf_host_inst.frame('0, 3, 0, 9);
    chk("mode_off", 32'(mode_active), 32'h0);
    fr('0, 0, 9);
    fr({96'h0, cmd(3'h0, 5'h1f, 1'b0, 7'h05, 8'ha5)}, 0, 9);
    dreg(7'h05, 8'h00);
  endtask : t_mode
  task automatic t_id;
    fr({96'h0, cmd(3'h6, 5'h07, 1'b1, 7'h11, 8'hee)}, 34, 9);
    axi_rd(`TCAF_AXI_STATUS);
    chk("status_id", d, 32'h0303);
    dreg(7'h17, 8'h03);
  endtask : t_id
  task automatic t_audio;
    fr({32'habcd_ef00, 32'h1234_5600, 32'h7777_7700, 32'h0}, 32, 9);
    chk("left", 32'(audio_left), 32'h0012_3456);
    chk("right", 32'(audio_right), 32'h00ab_cdef);
    axi_rd(`TCAF_AXI_LEFT);
    chk("left_axi", d, 32'h0012_3456);
    axi_rd(`TCAF_AXI_RIGHT);
    chk("right_axi", d, 32'h00ab_cdef);
    chk("tok_s2", 32'(tcaf_host_inst.tok_seen[80]), 32'h0);
    chk("tok_s3", 32'(tcaf_host_inst.tok_seen[112]), 32'h1);
  endtask : t_audio
  task automatic t_ext;
    fr({32'h5555_5500, 32'h6666_6600, cmd(3'h0, 5'h1f, 1'b0, 7'h08, 8'h5a),
      cmd(3'h2, 5'h00, 1'b0, 7'h07, 8'h3c)}, 32, 9);
    dreg(7'h07, 8'h00);
    dreg(7'h08, 8'h5a);
    chk("left_ext", 32'(audio_left), 32'h0012_3456);
    chk("tok_ext", 32'(tcaf_host_inst.tok_seen[80]), 32'h1);
  endtask : t_ext
  task automatic t_read;
    wreg(7'h09, 8'hc3);
    fr({96'h0, cmd(3'h1, 5'h03, 1'b1, 7'h09, 8'h00)}, 32, 0);
    chk("en_chain", 32'(tcaf_host_inst.en_hits), 32'h0);
    fr({32'h0, 32'h0c0c_0c00, 32'h0, cmd(3'h0, 5'h03, 1'b1, 7'h09, 8'h00)},
      32, 0);
    chk("rd", 32'(tcaf_host_inst.rd_byte), 32'hc3);
    chk("left_rd", 32'(audio_left), 32'h000c_0c0c);
    chk("en_bits", 32'(tcaf_host_inst.en_hits), 32'h9);
  endtask : t_read
  task automatic t_off;
    wreg(7'h13, 8'h10);
    fr({32'h0f0f_0f00, 32'h0e0e_0e00, 64'h0}, 32, 9);
    chk("left_off", 32'(audio_left), 32'h000c_0c0c);
    chk("tok_off", 32'(tcaf_host_inst.tok_seen[80]), 32'h1);
  endtask : t_off
  task automatic final_report;
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    #600us;
    err_total++;
    final_report();
  end
  initial begin
    err_total = 0;
    total_checks = 0;
    aresetn = 1'b0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hf;
    repeat (10) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_axi();
    t_mode();
    t_id();
    t_audio();
    t_ext();
    t_read();
    t_off();
    final_report();
  end
endmodule : tcaf_port_bench
